/* core/oslat_top.sv */
// Serial slave port of an eight-channel low-side switch with output latch.
// Assumes serial pins asynchronous to clk; clk far faster than the link.
// Contract
// - Eight switch outputs, each set by one bit of the command word.
// - Command bit zero turns its output on, one turns it off.
// - Serial transfers happen only while select is held low.
// - Rising select copies the shift register into the output latch.
// - Falling select loads drain status of every output into the shifter.
// - Serial output driver enabled whenever select is low.
// - Serial input sampled into the shifter on each falling clock edge.
// - Serial output advances to next bit on each rising clock edge after the first.
// - Deselected: ignore clock and input, serial output high impedance.
// - Each clock cycle moves one bit in and one bit out.
// - Cascading: serial output of one feeds input of the next.
// - Most significant bit first; first bit controls output seven.
// - Status bit high for off unfaulted output, low for on unfaulted.
// - Clear empties shifter, forces outputs off, leaves serial output.
`timescale 1ns/1ps
module oslat_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic clr_n,
  input wire logic [7:0] drain_stat,
  output logic sdo_o,
  output logic sdo_oe_n,
  output logic [7:0] sw_on,
  output logic [7:0] cmd_word,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_drop
);
  // Two-stage synchronisers; stage one is read only by stage two
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic sel_prev_q;
  logic sclk_prev_q;
  logic [7:0] shift_q;
  logic [7:0] latch_q;
  logic sdo_q;
  logic oe_n_q;
  logic [7:0] sw_on_q;
  logic [2:0] bit_cnt_q;
  logic full_q;
  logic drop_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Both stages rest at pin idle levels, so no false edge follows reset
      s1_q <= oslat_pkg::SYNC_IDLE;
      s2_q <= oslat_pkg::SYNC_IDLE;
    end else begin
      s1_q <= {clr_n, sel_n, sclk, sdi};
      s2_q <= s1_q;
    end
  end

  wire sdi_s = s2_q[0];
  wire sclk_s = s2_q[1];
  wire sel_s = s2_q[2];
  wire clr_s = ~s2_q[3];
  wire sel_fall = sel_prev_q && !sel_s;
  wire sel_rise = !sel_prev_q && sel_s;
  wire active = !sel_s && !sel_prev_q;
  wire sclk_fall = active && sclk_prev_q && !sclk_s;
  wire sclk_rise = active && !sclk_prev_q && sclk_s;
  wire [7:0] shift_in = {shift_q[6:0], sdi_s};
  wire fifo_in_ready;
  wire push_word = sel_rise && full_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_s;
      sclk_prev_q <= sclk_s;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clr_s) begin
      shift_q <= oslat_pkg::SHIFT_RST;
    end else if (sel_fall) begin
      shift_q <= drain_stat;
    end else if (sclk_fall) begin
      shift_q <= shift_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clr_s) begin
      latch_q <= oslat_pkg::LATCH_OFF;
    end else if (sel_rise) begin
      latch_q <= shift_q;
    end
  end

  // Serial output ignores clear so a cascade keeps its data path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdo_q <= 1'b0;
    end else if (sel_fall) begin
      sdo_q <= drain_stat[7];
    end else if (sclk_rise) begin
      sdo_q <= shift_q[7];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oe_n_q <= 1'b1;
      sw_on_q <= 8'h00;
    end else begin
      oe_n_q <= sel_s;
      sw_on_q <= ~latch_q;
    end
  end

  // Bit counter flags a full word; short frames are not queued
  always_ff @(posedge clk) begin
    if (sys_rst || sel_fall) begin
      bit_cnt_q <= oslat_pkg::BIT_CNT_RST;
      full_q <= 1'b0;
    end else if (sclk_fall) begin
      bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
      if (bit_cnt_q == oslat_pkg::BIT_CNT_LAST) full_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= push_word && !fifo_in_ready;
    end
  end

  oslat_fifo #(
    .WIDTH(oslat_pkg::WORD_W),
    .DEPTH(oslat_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(shift_q),
    .in_valid(push_word),
    .in_ready(fifo_in_ready),
    .out_data(cmd_word),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready)
  );

  assign sdo_o = sdo_q;
  assign sdo_oe_n = oe_n_q;
  assign sw_on = sw_on_q;
  assign cmd_drop = drop_q;

  sequence s_rise_seen;
    !sel_prev_q && sel_s && !clr_s;
  endsequence

  sequence s_fall_seen;
    sel_prev_q && !sel_s;
  endsequence

  // Serial output moves only on select fall or a clock rise
  AST_SDO_ON_FALL: assert property (@(posedge clk) disable iff (sys_rst)
    s_fall_seen |=> sdo_o == $past(drain_stat[7]))
    else $error("Serial output not first status bit");
  AST_SDO_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !sel_fall && !sclk_rise |=> $stable(sdo_o))
    else $error("Serial output moved without clock rise");
  AST_SDO_IGNORES_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    clr_s && !sel_fall && !sclk_rise |=> $stable(sdo_o))
    else $error("Clear disturbed serial output");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !sel_rise && !clr_s |=> $stable(latch_q))
    else $error("Latch changed without select rise");
  AST_WORD_FULL: assert property (@(posedge clk) disable iff (sys_rst)
    sclk_fall && bit_cnt_q == oslat_pkg::BIT_CNT_LAST |=> full_q)
    else $error("Eight bits did not flag a full word");
  AST_PUSH_VALID: assert property (@(posedge clk) disable iff (sys_rst)
    push_word && fifo_in_ready |=> cmd_valid)
    else $error("Committed word not queued");
  AST_DROP_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    push_word && !fifo_in_ready |=> cmd_drop)
    else $error("Overflow not flagged");

  AST_LATCH_ON_RISE: assert property (@(posedge clk) disable iff (sys_rst)
    s_rise_seen |=> latch_q == $past(shift_q))
    else $error("Latch not loaded on select rise");
  AST_STATUS_ON_FALL: assert property (@(posedge clk) disable iff (sys_rst)
    sel_fall && !clr_s |=> shift_q == $past(drain_stat))
    else $error("Status not loaded on select fall");
  AST_OE_FOLLOWS_SEL: assert property (@(posedge clk) disable iff (sys_rst)
    !sel_s |=> !sdo_oe_n)
    else $error("Output driver off while selected");
  AST_OE_OFF_DESEL: assert property (@(posedge clk) disable iff (sys_rst)
    sel_s |=> sdo_oe_n)
    else $error("Output driver on while deselected");
  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (sys_rst)
    sclk_fall && !clr_s |=> shift_q == $past(shift_in))
    else $error("Serial input not shifted");
  AST_NO_SHIFT_DESEL: assert property (@(posedge clk) disable iff (sys_rst)
    sel_s && sel_prev_q && !clr_s |=> $stable(shift_q))
    else $error("Shifter moved while deselected");
  AST_SDO_MSB: assert property (@(posedge clk) disable iff (sys_rst)
    sclk_rise |=> sdo_o == $past(shift_q[7]))
    else $error("Serial output not shifter MSB");
  AST_INVERT: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 sw_on == ~$past(latch_q))
    else $error("Output polarity wrong");
  AST_CLEAR_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    clr_s |=> latch_q == oslat_pkg::LATCH_OFF ##1 sw_on == 8'h00)
    else $error("Clear did not force outputs off");
endmodule

/* core/oslat_pkg.sv */
// Constants shared by the octal switch serial latch and its FIFO.
// Assumes a 100 MHz system clock sampling slow serial pins.
package oslat_pkg;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] LATCH_OFF = 8'hFF;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  // Pin rest levels {clr_n, sel_n, sclk, sdi}: not cleared, deselected
  localparam logic [3:0] SYNC_IDLE = 4'hC;
endpackage

/* core/oslat_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module oslat_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= AW'(wr_q + 1'b1);
      if (pop) rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
    end
  end
endmodule

/* sim/oslat_master.sv */
// SPI master model for the octal switch serial port.
// Assumes data is taken on falling and driven on rising serial clock.
`timescale 1ns/1ps
module oslat_master (
  output logic sel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo_o
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Shifts n bits MSB first and returns what came back serially
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    sel_n = 1'b0;
    #125;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #31.25 sclk = 1'b1;
      #62.5 rx = {rx[14:0], sdo_o};
      sclk = 1'b0;
      #31.25;
    end
    #62.5 sel_n = 1'b1;
    // Released line must not keep looking like valid data
    sdi = ~sdi;
  endtask
  // Clock and data noise while deselected; the clock ends low
  task automatic noise();
    repeat (8) begin
      #62.5 sclk = 1'b1;
      sdi = ~sdi;
      #62.5 sclk = 1'b0;
    end
  endtask
endmodule

/* sim/test_octal_switch_spi_latch.sv */
// Self-checking bench for the octal switch serial latch.
// Assumes the master model drives the serial pins asynchronously.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module test_octal_switch_spi_latch;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clr_n = 1'b1;
  logic cmd_ready = 1'b0;
  logic [7:0] drain_stat = 8'hFF;
  logic [15:0] rx;
  logic [7:0] exp_q[$];
  logic [7:0] head;
  wire sel_n, sclk, sdi, sdo_o, sdo_oe_n, cmd_valid, cmd_drop;
  wire [7:0] sw_on, cmd_word;
  int fail_count = 0;
  int samples_checked = 0;
  int drops = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (cmd_drop === 1'b1) drops++;
  oslat_top i_oslat_top (.clk(clk), .sys_rst(sys_rst), .sel_n(sel_n),
    .sclk(sclk), .sdi(sdi), .clr_n(clr_n), .drain_stat(drain_stat),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sw_on(sw_on),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_drop(cmd_drop));
  oslat_master i_oslat_master (.sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .sdo_o(sdo_o));
  task end_sim;
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One frame; FIFO stays stalled, so words past 32 are expected dropped
  task xfer(input logic [15:0] tx, input int n);
    fork
      i_oslat_master.frame(tx, n, rx);
      begin
        #300 `CHK("oe_n", 1'b0, sdo_oe_n)
      end
    join
    if (n >= 8 && exp_q.size() < 32) exp_q.push_back(tx[7:0]);
    repeat (8) @(posedge clk);
    #1 `CHK("oe_n", 1'b1, sdo_oe_n)
  endtask
  task t_write;
    drain_stat = 8'h3C;
    xfer(16'h00A5, 8);
    `CHK("status", 8'h3C, rx[7:0])
    `CHK("sw_on", 8'h5A, sw_on)
    `CHK("cmd_word", 8'hA5, cmd_word)
  endtask
  task t_cascade;
    drain_stat = 8'h81;
    xfer(16'hC35E, 16);
    `CHK("chain", 16'h81C3, rx)
    `CHK("sw_on", 8'hA1, sw_on)
  endtask
  task t_ignore;
    i_oslat_master.noise();
    repeat (8) @(posedge clk);
    #1 `CHK("sw_on", 8'hA1, sw_on)
  endtask
  task t_clear;
    clr_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 `CHK("sw_on", 8'h00, sw_on)
    clr_n = 1'b1;
  endtask
  // Stalling consumer drains the words in commit order
  task t_drain;
    for (int c = 0; c < 300 && exp_q.size() > 0; c++) begin
      @(posedge clk);
      #1 cmd_ready = c[1];
      // Head is settled here and is popped at the coming edge
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
        head = exp_q.pop_front();
        `CHK("fifo", head, cmd_word)
      end
    end
    `CHK("left", 0, exp_q.size())
    @(posedge clk);
    #1 `CHK("empty", 1'b0, cmd_valid)
  endtask
  initial begin
    #200000 fail_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK("sw_on", 8'h00, sw_on)
    `CHK("valid", 1'b0, cmd_valid)
    t_write();
    t_cascade();
    t_ignore();
    t_clear();
    for (int k = 0; k < 32; k++) xfer({8'h00, 8'(k * 7)}, 8);
    `CHK("drops", 2, drops)
    t_drain();
    end_sim;
  end
endmodule
